// >>> rtl/mic_interrupt_ctrl.sv
// Interrupt controller top: flags, enables, vectoring and wake-up
`timescale 1ns/100ps
module mic_interrupt_ctrl #(
    // Source order: pin0, pin1, pin2, comparator, shared0..2
    parameter logic [2:0] PRIO_0 = 3'h0,
    parameter logic [2:0] PRIO_1 = 3'h1,
    parameter logic [2:0] PRIO_2 = 3'h2,
    parameter logic [2:0] PRIO_3 = 3'h3,
    parameter logic [2:0] PRIO_4 = 3'h4,
    parameter logic [2:0] PRIO_5 = 3'h5,
    parameter logic [2:0] PRIO_6 = 3'h6,
    parameter logic [11:0] VEC_BASE = 12'h004,
    parameter logic [11:0] VEC_STEP = 12'h004,
    // Shared vector holding timer group and EEPROM group
    parameter int TMR_SV = 1,
    parameter int EE_SV = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // External pins and events
    input wire logic [2:0] extPin,
    input wire logic cmpOut,
    input wire logic [3:0] timerMatch,
    input wire logic brownoutEvt,
    input wire logic eepromEvt,
    input wire logic shared0Evt,
    // Core side
    input wire logic [11:0] nextPc,
    input wire logic stackFull,
    input wire logic returnFromInterrupt,
    input wire logic coreReady,
    output logic irqTake,
    output logic [11:0] irqVector,
    output logic [11:0] pushPc,
    output logic pushValid,
    output logic popReq,
    output logic wakeUp
);
    // Register state
    logic gie_r;
    logic [2:0] pinEn_r, pinFlag_r, pinSel_r, pinDir_r;
    logic cmpEn_r, cmpFlag_r, cmpPrev_r;
    logic [2:0] svEn_r, svFlag_r;
    logic [5:0] edge_r;
    logic [7:0] tmrGrp_r;
    logic [1:0] eeFlag_r, eeEn_r;
    mic_pkg::mic_state_t state_r;
    logic [2:0] taken_r;

    // Address decode
    wire wr0 = regWr && regAddr == mic_pkg::ADDR_CTRL0;
    wire wr1 = regWr && regAddr == mic_pkg::ADDR_CTRL1;
    wire wr2 = regWr && regAddr == mic_pkg::ADDR_CTRL2;
    wire wrE = regWr && regAddr == mic_pkg::ADDR_EDGE;
    wire wrT = regWr && regAddr == mic_pkg::ADDR_TMR_GRP;
    wire wrG = regWr && regAddr == mic_pkg::ADDR_EE_GRP;

    // Pin edge events
    logic [2:0] pinHit;
    genvar g;
    generate
        for (g = 0; g < mic_pkg::NUM_PINS; g++) begin : gPin
            mic_edge_det uEdge (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .pinIn(extPin[g]),
                .pinActive(pinEn_r[g] & pinSel_r[g] & pinDir_r[g]),
                .edgeSel(edge_r[2*g +: 2]),
                .hit(pinHit[g])
            );
        end
    endgenerate

    // Comparator toggle and grouped source events
    wire cmpHit = cmpOut ^ cmpPrev_r;
    wire [3:0] tmrSet = timerMatch & ~tmrGrp_r[7:4];
    wire [1:0] eeSet = {eepromEvt, brownoutEvt} & ~eeFlag_r;
    wire tmrRise = |tmrSet;
    wire eeRise = |eeSet;
    logic [2:0] svSet;
    always_comb begin
        svSet = 3'h0;
        svSet[0] = shared0Evt;
        svSet[TMR_SV] = svSet[TMR_SV] | tmrRise;
        svSet[EE_SV] = svSet[EE_SV] | eeRise;
    end

    // Pending enabled sources in source order
    wire [6:0] srcFlag = {svFlag_r, cmpFlag_r, pinFlag_r};
    wire [6:0] srcEn = {svEn_r, cmpEn_r, pinEn_r};
    wire [6:0] srcReq = srcFlag & srcEn;
    // Map to priority positions
    wire [2:0] prio [7] = '{PRIO_6, PRIO_5, PRIO_4, PRIO_3, PRIO_2,
                            PRIO_1, PRIO_0};
    logic [6:0] prioReq;
    always_comb begin
        prioReq = 7'h00;
        for (int i = 0; i < mic_pkg::NUM_SRC; i++) begin
            prioReq[prio[6-i]] = srcReq[i];
        end
    end
    logic anyReq;
    logic [2:0] winPos;
    mic_prio_enc #(.N(mic_pkg::NUM_SRC)) uPrio (
        .req(prioReq),
        .any(anyReq),
        .idx(winPos)
    );
    logic [2:0] winSrc;
    always_comb begin
        winSrc = 3'h0;
        for (int i = 0; i < mic_pkg::NUM_SRC; i++) begin
            if (prio[6-i] == winPos) winSrc = 3'(i);
        end
    end
    // take only with global enable and stack room
    wire take = (state_r == mic_pkg::ST_RUN) && gie_r && anyReq
                && !stackFull && coreReady;
    wire [6:0] clrSrc = take ? (7'h01 << winSrc) : 7'h00;

    // Global enable
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gie_r <= 1'b0;
        end else if (take) begin
            gie_r <= 1'b0;
        end else if (wr0) begin
            gie_r <= regWdata[mic_pkg::GIE_BIT];
        end
    end

    // Pin enables, flags, select and direction
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pinEn_r <= 3'h0;
            pinFlag_r <= 3'h0;
            cmpEn_r <= 1'b0;
            pinSel_r <= 3'h0;
            pinDir_r <= 3'h0;
            edge_r <= 6'h00;
        end else begin
            if (wr0) begin
                pinEn_r <= regWdata[mic_pkg::PIN_EN_LSB +: 3];
                cmpEn_r <= regWdata[mic_pkg::CMP_EN_BIT];
            end
            pinFlag_r <= ((wr0 ? regWdata[mic_pkg::PIN_FLAG_LSB +: 3]
                           : pinFlag_r) & ~clrSrc[2:0]) | pinHit;
            if (wr2) begin
                pinSel_r <= regWdata[mic_pkg::PIN_SEL_LSB +: 3];
                pinDir_r <= regWdata[mic_pkg::PIN_DIR_LSB +: 3];
            end
            if (wrE) edge_r <= regWdata[5:0];
        end
    end

    // Comparator and shared flags
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmpFlag_r <= 1'b0;
            cmpPrev_r <= 1'b0;
            svEn_r <= 3'h0;
            svFlag_r <= 3'h0;
        end else begin
            cmpPrev_r <= cmpOut;
            cmpFlag_r <= ((wr1 ? regWdata[mic_pkg::CMP_FLAG_BIT]
                           : cmpFlag_r) & ~clrSrc[3]) | cmpHit;
            if (wr1) svEn_r <= regWdata[mic_pkg::SV_EN_LSB +: 3];
            svFlag_r <= ((wr1 ? regWdata[mic_pkg::SV_FLAG_LSB +: 3]
                          : svFlag_r) & ~clrSrc[6:4]) | svSet;
        end
    end

    // Group registers; source flags never cleared by service
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tmrGrp_r <= mic_pkg::RST_REG;
            eeFlag_r <= 2'h0;
            eeEn_r <= 2'h0;
        end else begin
            tmrGrp_r[3:0] <= wrT ? regWdata[3:0] : tmrGrp_r[3:0];
            tmrGrp_r[7:4] <= (wrT ? regWdata[7:4] : tmrGrp_r[7:4])
                             | timerMatch;
            eeFlag_r <= (wrG ? regWdata[mic_pkg::EE_FLAG_LSB +: 2]
                         : eeFlag_r) | {eepromEvt, brownoutEvt};
            if (wrG) eeEn_r <= regWdata[mic_pkg::EE_EN_LSB +: 2];
        end
    end

    // Vector sequencing: one cycle in ST_WAIT after take, then back to ST_RUN
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_r <= mic_pkg::ST_RUN;
            taken_r <= 3'h0;
        end else begin
            case (state_r)
                mic_pkg::ST_RUN: begin
                    if (take) begin
                        state_r <= mic_pkg::ST_WAIT;
                        taken_r <= winSrc;
                    end
                end
                mic_pkg::ST_WAIT: begin
                    // Nested entries allowed once enable is set again
                    state_r <= mic_pkg::ST_RUN;
                end
                default: state_r <= mic_pkg::ST_RUN;
            endcase
        end
    end

    // Core-facing outputs, all registered
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irqTake <= 1'b0;
            irqVector <= 12'h000;
            pushPc <= 12'h000;
            pushValid <= 1'b0;
            popReq <= 1'b0;
            wakeUp <= 1'b0;
        end else begin
            irqTake <= take;
            pushValid <= take;
            if (take) begin
                pushPc <= nextPc;
                irqVector <= VEC_BASE + VEC_STEP * 12'(winSrc);
            end
            popReq <= returnFromInterrupt;
            wakeUp <= |srcFlag | (|tmrGrp_r[7:4]) | (|eeFlag_r);
        end
    end

    // Read mux
    logic [7:0] rdMux;
    always_comb begin
        case (regAddr)
            mic_pkg::ADDR_CTRL0: rdMux = {pinFlag_r, cmpEn_r, pinEn_r,
                                          gie_r};
            mic_pkg::ADDR_CTRL1: rdMux = {1'b0, svFlag_r, svEn_r,
                                          cmpFlag_r};
            mic_pkg::ADDR_CTRL2: rdMux = {2'h0, pinDir_r, pinSel_r};
            mic_pkg::ADDR_EDGE: rdMux = {2'h0, edge_r};
            mic_pkg::ADDR_TMR_GRP: rdMux = tmrGrp_r;
            mic_pkg::ADDR_EE_GRP: rdMux = {2'h0, eeFlag_r, 2'h0, eeEn_r};
            mic_pkg::ADDR_STATUS: rdMux = {4'h0, taken_r, gie_r};
            default: rdMux = 8'h00;
        endcase
    end

    // Read data one cycle after strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regRd ? rdMux : 8'h00;
        end
    end
endmodule : mic_interrupt_ctrl

// >>> pkg/mic_pkg.sv
// Package with constants and types for the interrupt controller
// Operation
// - Source event sets flag regardless of enable; pin edges set pin flag only while pin enabled
// - Disabled source keeps flag, no vectoring
// - Global enable low blocks every interrupt
// - Take: push return address, load vector
// - Return pops saved program counter
// - Servicing clears global enable automatically
// - Flags still latch while globally disabled
// - Full stack blocks acknowledge until pop
// - Simultaneous requests served by fixed priority
// - Any set flag wakes from sleep
// - Pin edge per select sets pin flag
// - Edge select: rising, falling, both, off
// - Pin active only if enabled, selected, input
// - Pin service clears pin flag
// - Comparator toggle sets flag; service clears it
// - Three shared vectors from grouped sources
// - Grouped source flag sets shared flag
// - Shared service clears shared flag only
// - Timer group register layout, reset zero
// - EEPROM/low-voltage group layout, others zero
// - Edge codes 00 off,01 rise,10 fall,11 both
package mic_pkg;
    // Register offsets
    localparam logic [3:0] ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] ADDR_CTRL1 = 4'h1;
    localparam logic [3:0] ADDR_CTRL2 = 4'h2;
    localparam logic [3:0] ADDR_EDGE = 4'h3;
    localparam logic [3:0] ADDR_TMR_GRP = 4'h4;
    localparam logic [3:0] ADDR_EE_GRP = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // Control register 0 fields
    localparam int GIE_BIT = 0;
    localparam int PIN_EN_LSB = 1;
    localparam int CMP_EN_BIT = 4;
    localparam int PIN_FLAG_LSB = 5;
    // Control register 1 fields
    localparam int CMP_FLAG_BIT = 0;
    localparam int SV_EN_LSB = 1;
    localparam int SV_FLAG_LSB = 4;
    // Control register 2: pin function select and direction
    localparam int PIN_SEL_LSB = 0;
    localparam int PIN_DIR_LSB = 3;
    // Group register field positions
    localparam int TMR_FLAG_LSB = 4;
    localparam int EE_FLAG_LSB = 4;
    localparam int EE_EN_LSB = 0;
    // Edge select codes
    localparam logic [1:0] EDGE_OFF = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Source counts
    localparam int NUM_PINS = 3;
    localparam int NUM_SV = 3;
    localparam int NUM_SRC = 7;
    typedef enum logic [1:0] {ST_RUN, ST_PUSH, ST_WAIT} mic_state_t;
endpackage : mic_pkg

// >>> rtl/mic_edge_det.sv
// Edge detector for one external interrupt pin
`timescale 1ns/100ps
module mic_edge_det (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Pin and setup
    input wire logic pinIn,
    input wire logic pinActive,
    input wire logic [1:0] edgeSel,
    // Event
    output logic hit
);
    logic prev_r;
    wire rise = pinIn & ~prev_r;
    wire fall = ~pinIn & prev_r;

    // Previous pin level
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= pinIn;
        end
    end

    // Select edge type
    always_comb begin
        case (edgeSel)
            mic_pkg::EDGE_RISE: hit = rise & pinActive;
            mic_pkg::EDGE_FALL: hit = fall & pinActive;
            mic_pkg::EDGE_BOTH: hit = (rise | fall) & pinActive;
            default: hit = 1'b0;
        endcase
    end
endmodule : mic_edge_det

// >>> rtl/mic_prio_enc.sv
// Fixed priority selector over active sources
`timescale 1ns/100ps
module mic_prio_enc #(
    parameter int N = 7
) (
    // Requests
    input wire logic [N-1:0] req,
    // Result
    output logic any,
    output logic [2:0] idx
);
    // Lowest index wins
    always_comb begin
        any = 1'b0;
        idx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = 3'(i);
            end
        end
    end
endmodule : mic_prio_enc

// >>> sim/mic_interrupt_ctrl_assertions.sv
// Port checker for the interrupt controller
`timescale 1ns/100ps
module mic_ctrl_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Event and core side
    input wire logic brownoutEvt,
    input wire logic [11:0] nextPc,
    input wire logic stackFull,
    input wire logic returnFromInterrupt,
    input wire logic coreReady,
    input wire logic irqTake,
    input wire logic [11:0] irqVector,
    input wire logic [11:0] pushPc,
    input wire logic pushValid,
    input wire logic popReq,
    input wire logic wakeUp
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // Vectoring handshake
    AST_PUSH_PAIR: assert property (pushValid == irqTake)
        else $error("push and take differ");
    AST_SAVE_PC: assert property (irqTake |-> pushPc == $past(nextPc))
        else $error("wrong saved address");
    AST_FULL_HOLD: assert property (stackFull |=> !irqTake)
        else $error("take while stack full");
    AST_NOT_READY: assert property (!coreReady |=> !irqTake)
        else $error("take while core busy");
    AST_NO_NEST: assert property (irqTake |=> !irqTake)
        else $error("back to back take");
    AST_VEC_SET: assert property (irqTake |-> irqVector[1:0] == 2'h0
        && irqVector inside {[12'h004:12'h01c]})
        else $error("vector out of set");
    // Return and wake-up
    AST_POP_NEXT: assert property (returnFromInterrupt |=> popReq)
        else $error("missing pop");
    AST_WAKE_EVT: assert property (brownoutEvt |-> ##[1:2] wakeUp)
        else $error("no wake after event");
endmodule : mic_ctrl_checker

bind mic_interrupt_ctrl mic_ctrl_checker i_chk (
    .clk_sys(clk_sys), .nrst(nrst), .brownoutEvt(brownoutEvt),
    .nextPc(nextPc), .stackFull(stackFull),
    .returnFromInterrupt(returnFromInterrupt), .coreReady(coreReady),
    .irqTake(irqTake), .irqVector(irqVector), .pushPc(pushPc),
    .pushValid(pushValid), .popReq(popReq), .wakeUp(wakeUp)
);

// >>> sim/mic_core_model.sv
// Core model: program counter, return stack, return requests
`timescale 1ns/100ps
module mic_core_model #(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Controller side
    input wire logic pushValid,
    input wire logic [11:0] pushPc,
    input wire logic [11:0] irqVector,
    input wire logic popReq,
    output logic [11:0] nextPc,
    output logic stackFull,
    output logic returnFromInterrupt,
    output logic coreReady,
    // Bench control
    input wire logic retCmd,
    input wire logic slow
);
    logic [11:0] stk [$];
    // Depth changes nonblocking so stackFull moves only after the edge
    int depth;
    logic tick;
    // Push on take, pop on return, else step
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stk.delete();
            depth <= 0;
            nextPc <= 12'h100;
            tick <= 1'b0;
            returnFromInterrupt <= 1'b0;
        end else begin
            tick <= !tick;
            returnFromInterrupt <= retCmd;
            if (pushValid) begin
                stk.push_back(pushPc);
                depth <= depth + 1;
                nextPc <= irqVector;
            end else if (popReq && depth > 0) begin
                depth <= depth - 1;
                nextPc <= stk.pop_back();
            end else begin
                nextPc <= nextPc + 12'h001;
            end
        end
    end
    // Slow core accepts every other cycle
    assign coreReady = !slow || tick;
    assign stackFull = (depth >= DEPTH);
endmodule : mic_core_model

// >>> sim/mic_interrupt_ctrl_tb_top.sv
// Testbench for the interrupt controller with core model
`timescale 1ns/100ps
module mic_interrupt_ctrl_tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [2:0] extPin = 3'h0;
    logic cmpOut = 1'b0;
    logic [6:0] evt = 7'h00;
    logic retCmd = 1'b0;
    logic slow = 1'b0;
    logic [7:0] regRdata;
    logic [11:0] nextPc, irqVector, pushPc, pcPrev;
    logic stackFull, rfi, coreReady, irqTake, pushValid, popReq, wakeUp;
    logic [7:0] mr [16];
    logic [7:0] msk [16];
    logic [11:0] takeQ [$];
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 94762;
    int c;
    always #50 clk_sys = ~clk_sys;
    mic_interrupt_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .extPin(extPin),
        .cmpOut(cmpOut), .timerMatch(evt[3:0]), .brownoutEvt(evt[4]),
        .eepromEvt(evt[5]), .shared0Evt(evt[6]), .nextPc(nextPc),
        .stackFull(stackFull), .returnFromInterrupt(rfi),
        .coreReady(coreReady), .irqTake(irqTake), .irqVector(irqVector),
        .pushPc(pushPc), .pushValid(pushValid), .popReq(popReq),
        .wakeUp(wakeUp));
    mic_core_model i_core (.clk_sys(clk_sys), .nrst(nrst),
        .pushValid(pushValid), .pushPc(pushPc), .irqVector(irqVector),
        .popReq(popReq), .nextPc(nextPc), .stackFull(stackFull),
        .returnFromInterrupt(rfi), .coreReady(coreReady),
        .retCmd(retCmd), .slow(slow));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk12
    // Record each take and check its saved address
    always @(negedge clk_sys) begin
        if (irqTake === 1'b1) begin
            takeQ.push_back(irqVector);
            chk12(pushPc, pcPrev);
        end
        pcPrev = nextPc;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        mr[a] = d & msk[a];
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        chk8(regRdata, mr[a]);
    endtask : rd
    task automatic fire(input logic [6:0] m);
        @(posedge clk_sys);
        evt <= m;
        @(posedge clk_sys);
        evt <= 7'h00;
        repeat (3) @(posedge clk_sys);
    endtask : fire
    task automatic pins(input logic [2:0] p);
        @(posedge clk_sys);
        extPin <= p;
        repeat (4) @(posedge clk_sys);
    endtask : pins
    task automatic take(input int idx);
        logic [11:0] v;
        repeat (20) if (takeQ.size() == 0) @(posedge clk_sys);
        v = (takeQ.size() > 0) ? takeQ.pop_front() : 12'hfff;
        chk12(v, 12'h004 + 12'h004 * idx[11:0]);
    endtask : take
    task automatic noTake;
        repeat (8) @(posedge clk_sys);
        chk12(12'(takeQ.size()), 12'h000);
    endtask : noTake
    task automatic ret;
        @(posedge clk_sys);
        retCmd <= 1'b1;
        @(posedge clk_sys);
        retCmd <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : ret
    task automatic wk(input logic e);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk8({7'h00, wakeUp}, {7'h00, e});
    endtask : wk
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    // Watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
    // Main sequence
    initial begin
        foreach (mr[i]) mr[i] = 8'h00;
        msk = '{0: 8'hff, 1: 8'h7f, 2: 8'h3f, 3: 8'h3f, 4: 8'hff,
                5: 8'h33, default: 8'h00};
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        for (c = 0; c < 8; c++) rd(c[3:0]);
        rd(4'hf);
        wr(4'h4, 8'($random(seed)));
        rd(4'h4);
        wr(4'h5, 8'hff);
        rd(4'h5);
        wk(1'b1);
        wr(4'h5, 8'h00);
        wr(4'h4, 8'h00);
        $display("register test done");
        wr(4'h2, 8'h3f);
        wr(4'h0, 8'h0e);
        for (c = 0; c < 4; c++) begin
            wr(4'h3, 8'(c));
            pins(3'h1);
            if (c[0]) mr[0] = 8'h2e;
            rd(4'h0);
            wr(4'h0, 8'h0e);
            pins(3'h0);
            if (c[1]) mr[0] = 8'h2e;
            rd(4'h0);
            wr(4'h0, 8'h0e);
        end
        wr(4'h2, 8'h37);
        wr(4'h3, 8'h01);
        pins(3'h1);
        rd(4'h0);
        pins(3'h0);
        $display("edge test done");
        wr(4'h1, 8'h08);
        cmpOut <= 1'b1;
        fire(7'h10);
        mr[1] = 8'h49;
        mr[5] = 8'h10;
        rd(4'h1);
        rd(4'h5);
        noTake();
        wr(4'h0, 8'h01);
        take(6);
        mr[0] = 8'h00;
        mr[1] = 8'h09;
        rd(4'h0);
        rd(4'h1);
        rd(4'h5);
        ret();
        wr(4'h0, 8'h11);
        take(3);
        mr[0] = 8'h10;
        mr[1] = 8'h08;
        rd(4'h1);
        ret();
        $display("shared test done");
        slow <= 1'b1;
        wr(4'h2, 8'h3f);
        wr(4'h3, 8'h05);
        wr(4'h0, 8'h0e);
        pins(3'h3);
        wr(4'h0, 8'h6f);
        take(0);
        mr[0] = 8'h4e;
        rd(4'h0);
        wr(4'h0, 8'h4f);
        take(1);
        fire(7'h20);
        mr[5] = 8'h30;
        wr(4'h0, 8'h0f);
        noTake();
        mr[1] = 8'h48;
        rd(4'h1);
        ret();
        take(6);
        ret();
        ret();
        $display("priority test done");
        // Timer match and own source of shared 0, all vectoring off
        fire(7'h48);
        mr[1] = 8'h38;
        mr[4] = 8'h80;
        rd(4'h1);
        rd(4'h4);
        wr(4'h4, 8'h00);
        $display("timer group test done");
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        wk(1'b0);
        $display("wake test done");
        print_verdict();
    end
endmodule : mic_interrupt_ctrl_tb_top
